// file: common/bwt_pkg.sv
// Constants for the bus-failure and wake/thermal interrupt source block
package bwt_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SUMMARY    = 8'h07;
   localparam logic [7:0] ADDR_BUS_FAIL   = 8'h08;
   localparam logic [7:0] ADDR_WAKE_THERM = 8'h09;

   // ---------------------------------------------------------------
   // Widths, values after reset and the read-as-zero value
   // ---------------------------------------------------------------
   localparam int         REG_W            = 8;
   localparam int         WAKE_THERM_W     = 4;
   localparam int         EVENT_W          = 12;
   localparam logic [7:0] BUS_FAIL_RESET   = 8'h00;
   localparam logic [3:0] WAKE_THERM_RESET = 4'h0;
   localparam logic [7:0] READ_ZERO        = 8'h00;

   // ---------------------------------------------------------------
   // Bus-failure source field positions
   // ---------------------------------------------------------------
   localparam int BIT_BUS_DOMINANT   = 7;
   localparam int BIT_TXD_RXD_SHORT  = 6;
   localparam int BIT_RXD_RECESSIVE  = 5;
   localparam int BIT_TXD_DOMINANT   = 4;
   localparam int BIT_CANL_SUPPLY    = 3;
   localparam int BIT_CANL_GND       = 2;
   localparam int BIT_CANH_GND       = 1;
   localparam int BIT_CANH_SUPPLY    = 0;

   // ---------------------------------------------------------------
   // Wake/thermal source and summary field positions
   // ---------------------------------------------------------------
   localparam int BIT_TEMP_RECOVER   = 3;
   localparam int BIT_TEMP_WARN      = 2;
   localparam int BIT_LOCAL_WAKE     = 1;
   localparam int BIT_REMOTE_WAKE    = 0;
   localparam int SUM_BUS_FAIL       = 0;
   localparam int SUM_WAKE_THERM     = 1;

   // Decode of one register access
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
      reg_hit = strobe && (addr == target);
   endfunction : reg_hit

endpackage : bwt_pkg

// file: hdl/bwt_sync.sv
// Two-stage synchroniser for the detector event levels
`timescale 1ns/1ps

module bwt_sync #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } bwt_sync_state_type;

   bwt_sync_state_type state_ff;
   bwt_sync_state_type nxt_state;

   // Shift levels through both stages
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.stage1 = async_in;
      nxt_state.stage2 = state_ff.stage1;
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sync_out = state_ff.stage2;

   // Two-cycle latency, only once both stages ran out of reset
   sync_delay_a : assert property (@(posedge clk) disable iff (!reset_n)
      ($past(reset_n) && $past(reset_n, 2)) |->
         sync_out == $past(async_in, 2))
      else $error("synchroniser latency is not two cycles");

endmodule : bwt_sync

// file: hdl/bwt_irq_sources.sv
// Bus-failure and wake/thermal interrupt source registers with summary
`timescale 1ns/1ps

// Functional notes
// - A detected bus clamped dominant sets bit 7 of the bus-failure source.
// - A detected short of transmit and receive pins sets bus-failure bit 6.
// - A receive pin clamped recessive sets bus-failure bit 5.
// - A transmit pin clamped dominant sets bus-failure bit 4.
// - A short of CANL to supply sets bus-failure bit 3.
// - A short of CANL to ground sets bus-failure bit 2.
// - A short of CANH to supply sets bus-failure bit 0.
// - Thermal recovery sets wake/thermal bit 3 and bits 7 to 4 are reserved.
// - Temperature above the warning threshold sets wake/thermal bit 2.
// - A local wake on the wake pin sets wake/thermal bit 1.
// - A remote wake by a bus message sets wake/thermal bit 0.
// - Summary bit 0 is high while any bus-failure source is pending.
// - Summary bit 1 is high while any wake/thermal source is pending.
// - A short of CANH to ground sets bus-failure bit 1.
module bwt_irq_sources (
   // Clock and battery power-on reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Bus and pin failure detector levels
   input  wire logic       bus_dominant_det,
   input  wire logic       txd_rxd_short_det,
   input  wire logic       rxd_recessive_det,
   input  wire logic       txd_dominant_det,
   input  wire logic       canl_supply_det,
   input  wire logic       canl_gnd_det,
   input  wire logic       canh_gnd_det,
   input  wire logic       canh_supply_det,
   // Thermal and wake detector levels
   input  wire logic       temp_recover_det,
   input  wire logic       temp_warn_det,
   input  wire logic       local_wake_det,
   input  wire logic       remote_wake_det,
   // Register port from the serial control interface
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_wr_data,
   input  wire logic       reg_rd_en,
   output      logic [7:0] reg_rd_data,
   output      logic       reg_rd_valid,
   // Summary pending levels
   output      logic       bus_fail_pending,
   output      logic       wake_therm_pending
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [bwt_pkg::EVENT_W-1:0]      evt_prev;
      logic [bwt_pkg::REG_W-1:0]        bus_flags;
      logic [bwt_pkg::WAKE_THERM_W-1:0] wake_flags;
      logic                             bus_pend;
      logic                             wake_pend;
      logic [bwt_pkg::REG_W-1:0]        rd_data;
      logic                             rd_valid;
   } bwt_state_type;

   bwt_state_type                    state_ff;
   bwt_state_type                    nxt_state;
   logic [bwt_pkg::EVENT_W-1:0]      evt_raw;
   logic [bwt_pkg::EVENT_W-1:0]      evt_sync;
   logic [bwt_pkg::EVENT_W-1:0]      evt_rise;
   logic [bwt_pkg::REG_W-1:0]        bus_rise;
   logic [bwt_pkg::WAKE_THERM_W-1:0] wake_rise;
   logic [bwt_pkg::REG_W-1:0]        bus_clr;
   logic [bwt_pkg::WAKE_THERM_W-1:0] wake_clr;

   // ---------------------------------------------------------------
   // Event capture
   // ---------------------------------------------------------------
   // Gather detector levels in register bit order
   always_comb begin
      evt_raw = '0;
      evt_raw[bwt_pkg::BIT_BUS_DOMINANT]  = bus_dominant_det;
      evt_raw[bwt_pkg::BIT_TXD_RXD_SHORT] = txd_rxd_short_det;
      evt_raw[bwt_pkg::BIT_RXD_RECESSIVE] = rxd_recessive_det;
      evt_raw[bwt_pkg::BIT_TXD_DOMINANT]  = txd_dominant_det;
      evt_raw[bwt_pkg::BIT_CANL_SUPPLY]   = canl_supply_det;
      evt_raw[bwt_pkg::BIT_CANL_GND]      = canl_gnd_det;
      evt_raw[bwt_pkg::BIT_CANH_GND]      = canh_gnd_det;
      evt_raw[bwt_pkg::BIT_CANH_SUPPLY]   = canh_supply_det;
      evt_raw[bwt_pkg::REG_W + bwt_pkg::BIT_TEMP_RECOVER] = temp_recover_det;
      evt_raw[bwt_pkg::REG_W + bwt_pkg::BIT_TEMP_WARN]    = temp_warn_det;
      evt_raw[bwt_pkg::REG_W + bwt_pkg::BIT_LOCAL_WAKE]   = local_wake_det;
      evt_raw[bwt_pkg::REG_W + bwt_pkg::BIT_REMOTE_WAKE]  = remote_wake_det;
   end

   // Detector levels come from the analog side
   bwt_sync #(
      .WIDTH    (bwt_pkg::EVENT_W)
   ) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (evt_raw),
      .sync_out (evt_sync)
   );

   // One-cycle pulse on each rising detector level
   assign evt_rise  = evt_sync & ~state_ff.evt_prev;
   assign bus_rise  = evt_rise[bwt_pkg::REG_W-1:0];
   assign wake_rise = evt_rise[bwt_pkg::EVENT_W-1:bwt_pkg::REG_W];

   // Write-one-to-clear masks
   assign bus_clr  = bwt_pkg::reg_hit(reg_wr_en, reg_addr,
                                      bwt_pkg::ADDR_BUS_FAIL) ?
                     reg_wr_data : bwt_pkg::READ_ZERO;
   assign wake_clr = bwt_pkg::reg_hit(reg_wr_en, reg_addr,
                                      bwt_pkg::ADDR_WAKE_THERM) ?
                     reg_wr_data[bwt_pkg::WAKE_THERM_W-1:0] :
                     bwt_pkg::WAKE_THERM_RESET;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state          = state_ff;
      nxt_state.evt_prev = evt_sync;
      nxt_state.bus_flags  = (state_ff.bus_flags & ~bus_clr) | bus_rise;
      nxt_state.wake_flags = (state_ff.wake_flags & ~wake_clr) | wake_rise;
      nxt_state.bus_pend  = |nxt_state.bus_flags;
      nxt_state.wake_pend = |nxt_state.wake_flags;
      // Read answer, unmapped addresses return zero
      nxt_state.rd_valid = reg_rd_en;
      nxt_state.rd_data  = bwt_pkg::READ_ZERO;
      if (bwt_pkg::reg_hit(reg_rd_en, reg_addr, bwt_pkg::ADDR_BUS_FAIL)) begin
         nxt_state.rd_data = state_ff.bus_flags;
      end else if (bwt_pkg::reg_hit(reg_rd_en, reg_addr,
                                    bwt_pkg::ADDR_WAKE_THERM)) begin
         nxt_state.rd_data[bwt_pkg::WAKE_THERM_W-1:0] = state_ff.wake_flags;
      end else if (bwt_pkg::reg_hit(reg_rd_en, reg_addr,
                                    bwt_pkg::ADDR_SUMMARY)) begin
         nxt_state.rd_data[bwt_pkg::SUM_BUS_FAIL]   = state_ff.bus_pend;
         nxt_state.rd_data[bwt_pkg::SUM_WAKE_THERM] = state_ff.wake_pend;
      end
   end

   // State register, cleared by battery power-on reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff            <= '0;
         state_ff.bus_flags  <= bwt_pkg::BUS_FAIL_RESET;
         state_ff.wake_flags <= bwt_pkg::WAKE_THERM_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rd_data        = state_ff.rd_data;
   assign reg_rd_valid       = state_ff.rd_valid;
   assign bus_fail_pending   = state_ff.bus_pend;
   assign wake_therm_pending = state_ff.wake_pend;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   bus_dominant_a : assert property (
      $rose(evt_sync[bwt_pkg::BIT_BUS_DOMINANT]) |=>
         state_ff.bus_flags[bwt_pkg::BIT_BUS_DOMINANT])
      else $error("bus dominant flag not set");
   pin_short_a : assert property (
      $rose(evt_sync[bwt_pkg::BIT_TXD_RXD_SHORT]) |=>
         state_ff.bus_flags[bwt_pkg::BIT_TXD_RXD_SHORT])
      else $error("pin short flag not set");
   rxd_recessive_a : assert property (
      $rose(evt_sync[bwt_pkg::BIT_RXD_RECESSIVE]) |=>
         state_ff.bus_flags[bwt_pkg::BIT_RXD_RECESSIVE])
      else $error("receive clamp flag not set");
   txd_dominant_a : assert property (
      $rose(evt_sync[bwt_pkg::BIT_TXD_DOMINANT]) |=>
         state_ff.bus_flags[bwt_pkg::BIT_TXD_DOMINANT])
      else $error("transmit clamp flag not set");
   canl_shorts_a : assert property (
      (bus_rise[bwt_pkg::BIT_CANL_SUPPLY] || bus_rise[bwt_pkg::BIT_CANL_GND])
      |=> ((state_ff.bus_flags & $past(bus_rise)) == $past(bus_rise)))
      else $error("CANL short flag not set");
   canh_shorts_a : assert property (
      (bus_rise[bwt_pkg::BIT_CANH_SUPPLY] || bus_rise[bwt_pkg::BIT_CANH_GND])
      |=> ((state_ff.bus_flags & $past(bus_rise)) == $past(bus_rise)))
      else $error("CANH short flag not set");
   wake_set_a : assert property (
      (wake_rise != bwt_pkg::WAKE_THERM_RESET) |=>
         ((state_ff.wake_flags & $past(wake_rise)) == $past(wake_rise)))
      else $error("wake or thermal flag not set");
   flag_hold_a : assert property (
      ((state_ff.bus_flags & ~nxt_state.bus_flags & ~bus_clr) ==
       bwt_pkg::READ_ZERO) &&
      ((state_ff.wake_flags & ~nxt_state.wake_flags & ~wake_clr) ==
       bwt_pkg::WAKE_THERM_RESET))
      else $error("source flag dropped without a clear");
   reserved_zero_a : assert property (
      bwt_pkg::reg_hit(reg_rd_en, reg_addr, bwt_pkg::ADDR_WAKE_THERM) |=>
         reg_rd_valid && (reg_rd_data[7:4] == 4'h0) &&
         (reg_rd_data[3:0] == $past(state_ff.wake_flags)))
      else $error("wake/thermal read wrong");
   bus_summary_a : assert property (
      bus_fail_pending == (state_ff.bus_flags != bwt_pkg::READ_ZERO))
      else $error("bus summary mismatch");
   wake_summary_a : assert property (
      ##1 wake_therm_pending ==
         (state_ff.wake_flags != bwt_pkg::WAKE_THERM_RESET))
      else $error("wake summary mismatch");

   bus_event_c   : cover property (bus_rise != bwt_pkg::READ_ZERO);
   bus_clear_c   : cover property ($fell(bus_fail_pending));
   wake_read_c   : cover property (reg_rd_valid && wake_therm_pending);
   set_and_clr_c : cover property ((bus_rise & bus_clr) != bwt_pkg::READ_ZERO);

endmodule : bwt_irq_sources

// file: testbench/bwt_mcu_model.sv
// Microcontroller model driving the register port of the source block
`timescale 1ns/1ps

module bwt_mcu_model (
   // Clock
   input  wire logic       clk,
   // Register port toward the block
   output      logic [7:0] reg_addr,
   output      logic       reg_wr_en,
   output      logic [7:0] reg_wr_data,
   output      logic       reg_rd_en,
   input  wire logic [7:0] reg_rd_data,
   input  wire logic       reg_rd_valid
);
   // Idle port from time zero
   initial begin
      reg_addr    = 8'h00;
      reg_wr_en   = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en   = 1'b0;
   end

   // One-byte write, taken at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr    <= a;
      reg_wr_data <= d;
      reg_wr_en   <= 1'b1;
      @(posedge clk);
      reg_wr_en   <= 1'b0;
      reg_addr    <= ~a;  // Released lines carry junk
      reg_wr_data <= ~d;
   endtask : wr

   // One-byte read, answer sampled 1 ns after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clk);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_addr  <= ~a;
      #1;
      d = reg_rd_data;
      v = reg_rd_valid;
   endtask : rd
endmodule : bwt_mcu_model

// file: testbench/bwt_irq_sources_tb.sv
// Self-checking bench for the interrupt source registers
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module bwt_irq_sources_tb;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [11:0] det = 12'h000;
   logic [7:0]  addr, wr_data, rd_data;
   logic        wr_en, rd_en, rd_valid, bus_pend, wake_pend;
   int          num_errors = 0;
   int          n_checks = 0;

   // Clock at 100 MHz
   initial begin
      forever #5 clk = ~clk;
   end

   // Device under test, detectors packed bus 7..0 then wake 11..8
   bwt_irq_sources dut (.clk(clk), .reset_n(reset_n),
      .bus_dominant_det(det[7]), .txd_rxd_short_det(det[6]),
      .rxd_recessive_det(det[5]), .txd_dominant_det(det[4]),
      .canl_supply_det(det[3]), .canl_gnd_det(det[2]),
      .canh_gnd_det(det[1]), .canh_supply_det(det[0]),
      .temp_recover_det(det[11]), .temp_warn_det(det[10]),
      .local_wake_det(det[9]), .remote_wake_det(det[8]),
      .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
      .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
      .bus_fail_pending(bus_pend), .wake_therm_pending(wake_pend));

   // Register port partner
   bwt_mcu_model mcu (.clk(clk), .reg_addr(addr), .reg_wr_en(wr_en),
      .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data),
      .reg_rd_valid(rd_valid));

   // Read and compare one register
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      mcu.rd(a, d, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask : rd_chk

   // Raise detector levels, let them cross the synchroniser
   task automatic raise(input logic [11:0] m);
      @(posedge clk);
      det <= det | m;
      repeat (5) @(posedge clk);
      #1;
   endtask : raise

   // One source: set, hold level, clear, no re-set, drop
   task automatic one_src(input int k, input logic [7:0] a,
                          input logic [7:0] e, input logic [7:0] s);
      raise(12'h001 << k);
      `CHK({wake_pend, bus_pend}, s[1:0])
      rd_chk(a, e);
      rd_chk(8'h07, s);
      mcu.wr(a, e);
      rd_chk(a, 8'h00);
      @(posedge clk);
      det <= 12'h000;
      #1;
      `CHK({wake_pend, bus_pend}, 2'b00)
   endtask : one_src

   task automatic t_reset();
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0b, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_bus();
      for (int i = 0; i < 8; i++) begin
         one_src(i, 8'h08, 8'h01 << i, 8'h01);
      end
      $display("test bus sources done");
   endtask : t_bus

   task automatic t_wake();
      for (int i = 0; i < 4; i++) begin
         one_src(8 + i, 8'h09, 8'h01 << i, 8'h02);
      end
      $display("test wake sources done");
   endtask : t_wake

   task automatic t_reserved();
      raise(12'hf00);
      rd_chk(8'h09, 8'h0f);
      mcu.wr(8'h09, 8'hf0);
      rd_chk(8'h09, 8'h0f);
      mcu.wr(8'h07, 8'hff);
      rd_chk(8'h07, 8'h02);
      mcu.wr(8'h09, 8'h05);
      rd_chk(8'h09, 8'h0a);
      @(posedge clk);
      det <= 12'h000;
      mcu.wr(8'h09, 8'h0a);
      rd_chk(8'h07, 8'h00);
      $display("test reserved done");
   endtask : t_reserved

   task automatic t_por();
      // New rising edge lands on the clearing write, set must win
      @(posedge clk);
      det <= 12'h001;
      @(posedge clk);
      mcu.wr(8'h08, 8'h01);
      rd_chk(8'h08, 8'h01);
      raise(12'h0ff);
      rd_chk(8'h08, 8'hff);
      mcu.wr(8'h08, 8'h0f);
      rd_chk(8'h08, 8'hf0);
      @(posedge clk);
      reset_n <= 1'b0;
      det     <= 12'h000;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(8'h08, 8'h00);
      `CHK({wake_pend, bus_pend}, 2'b00)
      $display("test power-on clear done");
   endtask : t_por

   // Closing report
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_bus();
      t_wake();
      t_reserved();
      t_por();
      give_verdict();
   end
endmodule : bwt_irq_sources_tb
